// file: core/control_field_pkg.sv
// package: register map, field layout, codes and carrier types of the control field builder
package control_field_pkg;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_COMPOSE  = 8'h04;
  localparam logic [7:0] ADR_ROUTE    = 8'h08;
  localparam logic [7:0] ADR_IDENT    = 8'h0C;
  localparam logic [7:0] ADR_QUALITY  = 8'h10;
  localparam logic [7:0] ADR_PID      = 8'h14;
  localparam logic [7:0] ADR_ECHO     = 8'h18;
  localparam logic [7:0] ADR_STATUS   = 8'h1C;
  localparam logic [7:0] ADR_REQ_BASE = 8'h20;
  localparam int         REQ_SLOTS    = 8;
  // control register bits
  localparam int CTRL_START   = 0;
  localparam int CTRL_MODE    = 1;
  localparam int CTRL_TS_EN   = 3;
  localparam int CTRL_PAYLOAD = 4;
  localparam int CTRL_SYNC    = 5;
  localparam int CTRL_LOGOFF  = 6;
  localparam int CTRL_ECHO    = 7;
  // composition register bits
  localparam int CMP_ROUTE = 0;
  localparam int CMP_QUAL  = 1;
  localparam int CMP_REQ   = 2;
  localparam int CMP_MC    = 3;
  localparam int CMP_GROUP = 4;
  localparam int CMP_LOGON = 5;
  localparam int CMP_COUNT = 8;
  localparam int CMP_LEN   = 16;
  // reset values
  localparam logic [12:0] RST_PID  = 13'h0000;
  localparam logic [15:0] RST_ECHO = 16'h8000;
  // maintenance and control codes
  localparam logic [15:0] MC_NONE     = 16'h0000;
  localparam logic [15:0] MC_SYNC     = 16'h0001;
  localparam logic [15:0] MC_LOGOFF   = 16'h0002;
  localparam logic [15:0] MC_ECHO_BIT = 16'h8000;
  // capacity request categories
  localparam logic [2:0] CAT_VOLUME   = 3'h0;
  localparam logic [2:0] CAT_RATE     = 3'h1;
  localparam logic [2:0] CAT_ABSOLUTE = 3'h2;
  localparam int         RATE_STEP_KBPS = 2;
  // transport packet wrapping
  localparam logic [7:0] TS_SYNC     = 8'h47;
  localparam logic [7:0] AF_FLAGS    = 8'h02;
  localparam logic [7:0] AF_OVERHEAD = 8'h02;
  localparam logic [7:0] COMP_BYTES  = 8'h02;
  localparam logic [5:0] TS_HDR_LEN  = 6'h07;
  localparam logic [1:0] AFC_ONLY    = 2'h2;
  localparam logic [1:0] AFC_PAYLOAD = 2'h3;

  typedef enum logic [1:0] {MODE_PREFIX, MODE_MINISLOT, MODE_CONTENTION, MODE_ADAPT} mode_t;
  typedef enum logic [3:0] {SEC_IDLE, SEC_TS, SEC_COMP, SEC_ROUTE, SEC_REQ, SEC_MC,
                            SEC_GROUP, SEC_LOGON, SEC_QUAL, SEC_PAD} section_t;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } stream_t;
  typedef struct packed {
    logic       scale;
    logic [2:0] category;
    logic [3:0] channel;
    logic [7:0] amount;
  } cap_req_t;
endpackage

// file: core/control_field_builder.sv
// control field builder: wishbone registers and byte-serial field framer
`timescale 1ns/1ps
module control_field_builder (
  input  wire logic                        clock_i,
  input  wire logic                        rst_i,
  input  wire control_field_pkg::wb_req_t  wb_i,
  output logic                             wb_ack_o,
  output logic [31:0]                      wb_dat_o,
  input  wire logic                        strm_ready_i,
  output control_field_pkg::stream_t       strm_o,
  output logic                             frame_busy_o
);
  import control_field_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic                 ack;
  logic [31:0]          rdata;
  mode_t                mode;
  logic                 ts_en;
  logic                 payload;
  logic                 sync_pend;
  logic                 logoff;
  logic                 echo_pend;
  logic [31:0]          compose;
  logic [15:0]          route;
  logic [7:0]           group_identifier;
  logic [15:0]          logon_identifier;
  logic [7:0]           carrier_noise_value;
  logic [7:0]           modcod;
  logic [12:0]          pid;
  logic [15:0]          echo;
  logic [15:0]          reqs [REQ_SLOTS];
  logic [3:0]           cc;
  logic                 go;
  section_t             sec;
  logic [5:0]           sub;
  logic [15:0]          mc_code;
  stream_t              strm;
  logic                 busy;

  logic                 next_ack;
  logic [31:0]          next_rdata;
  mode_t                next_mode;
  logic                 next_ts_en;
  logic                 next_payload;
  logic                 next_sync_pend;
  logic                 next_logoff;
  logic                 next_echo_pend;
  logic [31:0]          next_compose;
  logic [15:0]          next_route;
  logic [7:0]           next_group_identifier;
  logic [15:0]          next_logon_identifier;
  logic [7:0]           next_cni;
  logic [7:0]           next_modcod;
  logic [12:0]          next_pid;
  logic [15:0]          next_echo;
  logic [15:0]          next_reqs [REQ_SLOTS];
  logic [3:0]           next_cc;
  logic                 next_go;
  section_t             next_sec;
  logic [5:0]           next_sub;
  logic [15:0]          next_mc_code;
  stream_t              next_strm;
  logic                 next_busy;

  logic                 wr_fire;
  logic [31:0]          wmask;
  logic                 start_req;
  logic                 f_ts;
  logic                 f_route;
  logic                 f_qual;
  logic                 f_req;
  logic                 f_mc;
  logic                 f_group;
  logic                 f_logon;
  logic [2:0]           n_req;
  logic [5:0]           sum;
  logic [5:0]           clen;
  logic [9:0]           pres;
  section_t             first_sec;
  section_t             follow_sec;
  logic [5:0]           sec_len;
  logic [7:0]           out_byte;
  logic                 step;
  cap_req_t             cur_req;
  logic [7:0]           priv_len;

  // merge write data into a word under the byte lane selects
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // bus decode: a write lands at the edge that samples ack high, and is dropped while a frame is busy
  always_comb begin
    wr_fire = wb_i.cyc & wb_i.stb & wb_i.we & ack & ~busy;
    wmask = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}}, {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
    start_req = wr_fire & (wb_i.adr == ADR_CTRL) & wb_i.sel[0] & wb_i.dat[CTRL_START];
  end

  // effective composition per carriage mode
  always_comb begin
    f_mc = compose[CMP_MC];
    f_qual = compose[CMP_QUAL];
    f_ts = 1'b0;
    f_route = 1'b0;
    f_req = 1'b1;
    f_group = 1'b0;
    f_logon = 1'b0;
    unique case (mode)
      MODE_PREFIX:     f_route = 1'b1;
      MODE_MINISLOT:   f_req = 1'b1;
      MODE_CONTENTION: begin
        f_group = 1'b1;
        f_logon = 1'b1;
      end
      MODE_ADAPT: begin
        f_ts = ts_en;
        f_route = compose[CMP_ROUTE];
        f_req = compose[CMP_REQ];
        f_group = compose[CMP_GROUP];
        f_logon = compose[CMP_LOGON];
      end
    endcase
    // an empty request list still carries one zero request
    n_req = (compose[CMP_COUNT +: 3] == 3'h0) ? 3'h1 : compose[CMP_COUNT +: 3];
    sum = 6'({f_route, 1'b0}) + 6'({n_req, 1'b0}) * 6'(f_req) + 6'({f_mc, 1'b0})
        + 6'(f_group) + 6'({f_logon, 1'b0}) + 6'({f_qual, 1'b0});
    clen = (6'(compose[CMP_LEN +: 5]) > sum) ? 6'(compose[CMP_LEN +: 5]) : sum;
    priv_len = 8'(COMP_BYTES + 8'(clen));
    pres = {clen > sum, f_qual, f_logon, f_group, f_mc, f_req, f_route, f_ts, f_ts, 1'b0};
  end

  // next present section after the current one, and the first one of a frame
  always_comb begin
    first_sec = SEC_IDLE;
    follow_sec = SEC_IDLE;
    for (int i = 9; i > 0; i--) begin
      if (pres[i]) begin
        first_sec = section_t'(i);
      end
      if (pres[i] && (i > int'(sec))) begin
        follow_sec = section_t'(i);
      end
    end
  end

  // byte count of the current section
  always_comb begin
    sec_len = 6'h01;
    unique case (sec)
      SEC_TS:    sec_len = TS_HDR_LEN;
      SEC_REQ:   sec_len = 6'({n_req, 1'b0});
      SEC_GROUP: sec_len = 6'h01;
      SEC_PAD:   sec_len = clen - sum;
      SEC_IDLE:  sec_len = 6'h01;
      default:   sec_len = 6'h02;
    endcase
  end

  // request entry under the cursor, with category clean-up
  always_comb begin
    cur_req = cap_req_t'(reqs[sub[3:1]]);
    if (cur_req.category > CAT_ABSOLUTE) begin
      cur_req.category = CAT_VOLUME;
    end
    if ((compose[CMP_COUNT +: 3] == 3'h0) || (cur_req.amount == 8'h00)) begin
      cur_req = '{scale: 1'b0, category: CAT_VOLUME, channel: 4'h0, amount: 8'h00};
    end
  end

  // byte under the cursor, most significant byte first, except quality: noise value before modcod
  always_comb begin
    out_byte = 8'h00;
    unique case (sec)
      SEC_TS: begin
        unique case (sub[2:0])
          3'h0:    out_byte = TS_SYNC;
          3'h1:    out_byte = {1'b0, payload, 1'b0, pid[12:8]};
          3'h2:    out_byte = pid[7:0];
          3'h3:    out_byte = {2'h0, payload ? AFC_PAYLOAD : AFC_ONLY, cc};
          3'h4:    out_byte = 8'(AF_OVERHEAD + priv_len);
          3'h5:    out_byte = AF_FLAGS;
          default: out_byte = priv_len;
        endcase
      end
      SEC_COMP: begin
        out_byte = sub[0] ? {f_req, f_mc, f_group, f_logon, n_req & {3{f_req}}, 1'b0}
                          : {f_route, f_qual, 1'b0, clen[4:0]};
      end
      SEC_ROUTE: out_byte = sub[0] ? route[7:0] : route[15:8];
      SEC_REQ: begin
        // rate amounts stay raw; the hub scales them by the step
        out_byte = sub[0] ? cur_req.amount
                          : {cur_req.scale, cur_req.category, cur_req.channel};
      end
      SEC_MC:    out_byte = sub[0] ? mc_code[7:0] : mc_code[15:8];
      SEC_GROUP: out_byte = group_identifier;
      SEC_LOGON: out_byte = sub[0] ? logon_identifier[7:0] : logon_identifier[15:8];
      SEC_QUAL:  out_byte = sub[0] ? modcod : carrier_noise_value;
      SEC_PAD:   out_byte = 8'h00;
      SEC_IDLE:  out_byte = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // framer sequencer
  always_comb begin
    step = (sec != SEC_IDLE) & (~strm.valid | strm_ready_i);
    next_go = start_req;
    next_sec = sec;
    next_sub = sub;
    next_mc_code = mc_code;
    next_strm = strm;
    next_cc = cc;
    if (strm.valid && strm_ready_i) begin
      next_strm = '{valid: 1'b0, last: 1'b0, data: strm.data};
    end
    if (go) begin
      next_sec = first_sec;
      next_sub = 6'h00;
      // maintenance code priority: logoff, sync, echo, none
      if (logoff) begin
        next_mc_code = MC_LOGOFF;
      end else if (sync_pend) begin
        next_mc_code = MC_SYNC;
      end else if (echo_pend) begin
        next_mc_code = MC_ECHO_BIT | echo;
      end else begin
        next_mc_code = MC_NONE;
      end
      if (f_ts && payload) begin
        next_cc = cc + 4'h1;
      end
    end else if (step) begin
      next_strm.valid = 1'b1;
      next_strm.data = out_byte;
      next_strm.last = 1'b0;
      if (sub == sec_len - 6'h01) begin
        next_sec = follow_sec;
        next_sub = 6'h00;
        next_strm.last = (follow_sec == SEC_IDLE);
      end else begin
        next_sub = sub + 6'h01;
      end
    end
    next_busy = next_go | (next_sec != SEC_IDLE) | next_strm.valid;
  end

  //////////////////////////////////////////////////////////////////////////////
  // register file next values; one-shot codes clear when a frame takes them
  always_comb begin
    next_ack = wb_i.cyc & wb_i.stb & ~ack;
    next_rdata = rdata;
    next_mode = mode;
    next_ts_en = ts_en;
    next_payload = payload;
    next_sync_pend = sync_pend;
    next_logoff = logoff;
    next_echo_pend = echo_pend;
    next_compose = compose;
    next_route = route;
    next_group_identifier = group_identifier;
    next_logon_identifier = logon_identifier;
    next_cni = carrier_noise_value;
    next_modcod = modcod;
    next_pid = pid;
    next_echo = echo;
    next_reqs = reqs;
    if (go && f_mc && !logoff) begin
      if (sync_pend) begin
        next_sync_pend = 1'b0;
      end else begin
        next_echo_pend = 1'b0;
      end
    end
    if (wr_fire) begin
      unique case (wb_i.adr)
        ADR_CTRL: begin
          if (wb_i.sel[0]) begin
            next_mode = mode_t'(wb_i.dat[CTRL_MODE +: 2]);
            next_ts_en = wb_i.dat[CTRL_TS_EN];
            next_payload = wb_i.dat[CTRL_PAYLOAD];
            next_logoff = wb_i.dat[CTRL_LOGOFF];
            // a software set beats a same-cycle clear
            next_sync_pend = sync_pend | wb_i.dat[CTRL_SYNC];
            next_echo_pend = echo_pend | wb_i.dat[CTRL_ECHO];
          end
        end
        ADR_COMPOSE: next_compose = merge(compose, wb_i.dat, wmask);
        ADR_ROUTE:   next_route = 16'(merge({16'h0000, route}, wb_i.dat, wmask));
        ADR_IDENT: begin
          next_group_identifier = 8'(merge({24'h000000, group_identifier}, wb_i.dat, wmask));
          next_logon_identifier = 16'(merge({8'h00, logon_identifier, 8'h00}, wb_i.dat, wmask) >> 8);
        end
        ADR_QUALITY: begin
          next_cni = 8'(merge({24'h000000, carrier_noise_value}, wb_i.dat, wmask));
          next_modcod = 8'(merge({16'h0000, modcod, 8'h00}, wb_i.dat, wmask) >> 8);
        end
        ADR_PID:     next_pid = 13'(merge({19'h00000, pid}, wb_i.dat, wmask));
        ADR_ECHO:    next_echo = 16'(merge({16'h0000, echo}, wb_i.dat, wmask)) | MC_ECHO_BIT;
        default: begin
          if (wb_i.adr[7:5] == ADR_REQ_BASE[7:5]) begin
            next_reqs[wb_i.adr[4:2]] = 16'(merge({16'h0000, reqs[wb_i.adr[4:2]]},
                                                 wb_i.dat, wmask));
          end
        end
      endcase
    end
    if (wb_i.cyc && wb_i.stb && !ack) begin
      unique case (wb_i.adr)
        ADR_CTRL: next_rdata = {24'h000000, echo_pend, logoff, sync_pend, payload,
                                ts_en, mode, 1'b0};
        ADR_COMPOSE: next_rdata = compose & 32'h001F073F;
        ADR_ROUTE:   next_rdata = {16'h0000, route};
        ADR_IDENT:   next_rdata = {8'h00, logon_identifier, group_identifier};
        ADR_QUALITY: next_rdata = {16'h0000, modcod, carrier_noise_value};
        ADR_PID:     next_rdata = {19'h00000, pid};
        ADR_ECHO:    next_rdata = {16'h0000, echo};
        ADR_STATUS:  next_rdata = {20'h00000, cc, 4'(sec), 3'h0, busy};
        default: begin
          next_rdata = 32'h00000000;
          if (wb_i.adr[7:5] == ADR_REQ_BASE[7:5]) begin
            next_rdata = {16'h0000, reqs[wb_i.adr[4:2]]};
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdata <= 32'h00000000;
      mode <= MODE_PREFIX;
      ts_en <= 1'b0;
      payload <= 1'b0;
      sync_pend <= 1'b0;
      logoff <= 1'b0;
      echo_pend <= 1'b0;
      compose <= 32'h00000000;
      route <= 16'h0000;
      group_identifier <= 8'h00;
      logon_identifier <= 16'h0000;
      carrier_noise_value <= 8'h00;
      modcod <= 8'h00;
      pid <= RST_PID;
      echo <= RST_ECHO;
      for (int i = 0; i < REQ_SLOTS; i++) begin
        reqs[i] <= 16'h0000;
      end
      cc <= 4'h0;
      go <= 1'b0;
      sec <= SEC_IDLE;
      sub <= 6'h00;
      mc_code <= MC_NONE;
      strm <= '0;
      busy <= 1'b0;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      mode <= next_mode;
      ts_en <= next_ts_en;
      payload <= next_payload;
      sync_pend <= next_sync_pend;
      logoff <= next_logoff;
      echo_pend <= next_echo_pend;
      compose <= next_compose;
      route <= next_route;
      group_identifier <= next_group_identifier;
      logon_identifier <= next_logon_identifier;
      carrier_noise_value <= next_cni;
      modcod <= next_modcod;
      pid <= next_pid;
      echo <= next_echo;
      reqs <= next_reqs;
      cc <= next_cc;
      go <= next_go;
      sec <= next_sec;
      sub <= next_sub;
      mc_code <= next_mc_code;
      strm <= next_strm;
      busy <= next_busy;
    end
  end

  // outputs straight from flops
  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign strm_o = strm;
  assign frame_busy_o = busy;
endmodule

// file: test/control_field_builder_monitor.sv
// checker: bus handshake and stream framing relations at the builder's ports
`timescale 1ns/1ps
module control_field_builder_monitor
  import control_field_pkg::*;
(
  input wire logic                       clock_i,
  input wire logic                       rst_i,
  input wire control_field_pkg::wb_req_t wb_i,
  input wire logic                       wb_ack_o,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       strm_ready_i,
  input wire control_field_pkg::stream_t strm_o,
  input wire logic                       frame_busy_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // bus answers: one pulse, one cycle after a fresh request
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_latency: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked in the next cycle");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_i.cyc && wb_i.stb))
    else $error("ack without a request");

  ////////////////////////////////////////////////////////////////////////////
  // stream: bytes hold until taken, only inside a busy frame, frame ends on last
  chk_hold_byte: assert property (
    strm_o.valid && !strm_ready_i |=> strm_o.valid && $stable(strm_o.data) && $stable(strm_o.last))
    else $error("byte changed before it was taken");
  chk_valid_busy: assert property (strm_o.valid |-> frame_busy_o)
    else $error("byte offered outside a frame");
  chk_last_valid: assert property (strm_o.last |-> strm_o.valid)
    else $error("last flag without valid");
  chk_last_ends: assert property (
    strm_o.valid && strm_o.last && strm_ready_i |=> !frame_busy_o && !strm_o.valid)
    else $error("frame continues after last byte");
  chk_busy_drop: assert property (
    $fell(frame_busy_o) |-> $past(strm_o.valid && strm_o.last && strm_ready_i))
    else $error("busy fell before the last byte was taken");
  chk_start_busy: assert property (wb_ack_o && wb_i.we && wb_i.adr == ADR_CTRL && wb_i.sel[0]
    && wb_i.dat[CTRL_START] && !frame_busy_o |=> frame_busy_o ##[1:4] strm_o.valid)
    else $error("start did not open a frame");
endmodule

bind control_field_builder control_field_builder_monitor i_mon (
  .clock_i(clock_i), .rst_i(rst_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .strm_ready_i(strm_ready_i), .strm_o(strm_o), .frame_busy_o(frame_busy_o));

// file: test/hub_receiver_model.sv
// partner: hub-side byte sink that collects frames, prompt or stalling
`timescale 1ns/1ps
module hub_receiver_model
  import control_field_pkg::*;
(
  input  wire logic                       clock_i,
  input  wire logic                       rst_i,
  input  wire control_field_pkg::stream_t strm_i,
  input  wire logic                       stall_i,
  output logic                            strm_ready_o
);
  logic [1:0] phase;
  logic [8:0] got[$];

  // ready pattern: always high, or high one cycle in three when stalling
  always @(posedge clock_i) begin
    phase <= (rst_i || phase == 2'h2) ? 2'h0 : phase + 2'h1;
    strm_ready_o <= !rst_i && (!stall_i || phase == 2'h2);
  end

  // keep every taken byte in arrival order with its last flag
  always @(posedge clock_i) begin
    if (!rst_i && strm_i.valid && strm_ready_o) begin
      got.push_back({strm_i.last, strm_i.data});
    end
  end
endmodule

// file: test/control_field_builder_test.sv
// testbench: register access and frame content checks of the control field builder
`timescale 1ns/1ps
module control_field_builder_test;
  import control_field_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  wb_req_t     wb      = '0;
  logic        stall   = 1'b0;
  logic        wb_ack_o;
  logic [31:0] wb_dat_o;
  logic        ready;
  logic        frame_busy_o;
  stream_t     strm;
  logic [7:0]  exp_q[$];
  logic [31:0] q;
  int          num_errors = 0;
  int          samples_checked = 0;

  always #50 clock_i = ~clock_i;

  control_field_builder i_control_field_builder (.clock_i(clock_i), .rst_i(rst_i), .wb_i(wb),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .strm_ready_i(ready), .strm_o(strm),
    .frame_busy_o(frame_busy_o));
  hub_receiver_model i_hub_receiver_model (.clock_i(clock_i), .rst_i(rst_i), .strm_i(strm),
    .stall_i(stall), .strm_ready_o(ready));

  ////////////////////////////////////////////////////////////////////////////
  // verdict, comparison and bus access
  task give_verdict;
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clock_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: d};
    @(posedge clock_i);
    // only the watchdog ends this wait
    while (wb_ack_o !== 1'b1) begin
      @(posedge clock_i);
    end
    q = wb_dat_o;
    wb <= '0;
  endtask

  // start a frame, optionally poke the route while busy, compare collected bytes
  task frame(input logic [31:0] ctrl, input logic poke);
    i_hub_receiver_model.got.delete();
    wb_xfer(1'b1, ADR_CTRL, ctrl);
    if (poke) wb_xfer(1'b1, ADR_ROUTE, 32'h0000FFFF);
    @(posedge clock_i);
    // only the watchdog ends this wait
    while (frame_busy_o !== 1'b0) begin
      @(posedge clock_i);
    end
    check(32'(i_hub_receiver_model.got.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) begin
      if (i < i_hub_receiver_model.got.size())
        check({23'h0, i_hub_receiver_model.got[i]}, {23'h0, i == exp_q.size() - 1, exp_q[i]});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    give_verdict;
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    wb_xfer(1'b0, ADR_ECHO, 32'h0);
    check(q, 32'h00008000);
    wb_xfer(1'b0, ADR_PID, 32'h0);
    check(q, 32'h0);
    wb_xfer(1'b0, 8'h40, 32'h0);
    check(q, 32'h0);
    // prefix mode: route then one rate request; route write while busy is ignored
    wb_xfer(1'b1, ADR_ROUTE, 32'h00001234);
    wb_xfer(1'b1, ADR_COMPOSE, 32'h00000100);
    wb_xfer(1'b1, ADR_REQ_BASE, 32'h00001105);
    exp_q = '{8'h12, 8'h34, 8'h11, 8'h05};
    stall <= 1'b1;
    frame(32'h00000001, 1'b1);
    frame(32'h00000001, 1'b0);
    // contention: scaled absolute request, logoff, identifiers, two pad bytes
    wb_xfer(1'b1, ADR_COMPOSE, 32'h00090108);
    wb_xfer(1'b1, ADR_REQ_BASE, 32'h0000AA2F);
    wb_xfer(1'b1, ADR_IDENT, 32'h00BEEF5C);
    exp_q = '{8'hAA, 8'h2F, 8'h00, 8'h02, 8'h5C, 8'hBE, 8'hEF, 8'h00, 8'h00};
    frame(32'h00000045, 1'b0);
    // mini-slot: empty request, sync code once, then none, then echo reply
    stall <= 1'b0;
    wb_xfer(1'b1, ADR_COMPOSE, 32'h0000000A);
    wb_xfer(1'b1, ADR_QUALITY, 32'h00003CA7);
    exp_q = '{8'h00, 8'h00, 8'h00, 8'h01, 8'hA7, 8'h3C};
    frame(32'h00000023, 1'b0);
    exp_q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hA7, 8'h3C};
    frame(32'h00000003, 1'b0);
    wb_xfer(1'b1, ADR_ECHO, 32'h00001357);
    exp_q = '{8'h00, 8'h00, 8'h93, 8'h57, 8'hA7, 8'h3C};
    frame(32'h00000083, 1'b0);
    // adaptation carriage: transport header, composition header, field
    wb_xfer(1'b1, ADR_PID, 32'h00001ABC);
    wb_xfer(1'b0, ADR_PID, 32'h0);
    check(q, 32'h00001ABC);
    wb_xfer(1'b1, ADR_COMPOSE, 32'h00000115);
    wb_xfer(1'b1, ADR_REQ_BASE, 32'h00000307);
    exp_q = '{8'h47, 8'h1A, 8'hBC, 8'h20, 8'h09, 8'h02, 8'h07, 8'h85, 8'hA2,
              8'h12, 8'h34, 8'h03, 8'h07, 8'h5C};
    frame(32'h0000000F, 1'b0);
    exp_q = '{8'h12, 8'h34, 8'h03, 8'h07, 8'h5C};
    frame(32'h00000007, 1'b0);
    // payload follows: start indicator set, control 11, counter steps to 1
    exp_q = '{8'h47, 8'h5A, 8'hBC, 8'h31, 8'h09, 8'h02, 8'h07, 8'h85, 8'hA2,
              8'h12, 8'h34, 8'h03, 8'h07, 8'h5C};
    frame(32'h0000001F, 1'b0);
    wb_xfer(1'b0, ADR_STATUS, 32'h0);
    check(q, 32'h00000100);
    give_verdict;
  end
endmodule
